// *** hdl/dhl_core.sv ***
/*
  demand heating limit: filters outside temperature, compares against day
  and night limits with hysteresis, drives heating_off and the shutoff
  indication. assumes config and mode inputs are synchronous to core_clk.
*/
`timescale 1ns/1ps
module dhl_core
  import dhl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire dhl_source_t outside_sensor_input,
  input wire dhl_config_t cfg,
  input wire dhl_mode_t mode,
  input wire logic program_normal,
  output logic heating_off,
  output logic demand_shutoff,
  output logic signed [15:0] actual_outside_temp,
  output logic signed [15:0] composite_outside_temp,
  output logic signed [15:0] attenuated_outside_temp
);
  logic signed [15:0] day_lim_reg;
  logic signed [15:0] night_lim_reg;
  logic [5:0] tc_reg;
  logic signed [15:0] ta_reg;
  logic signed [15:0] ta_next;
  logic signed [15:0] f1;
  logic signed [15:0] f2;
  logic [15:0] tick_cnt_reg;
  logic sample_tick;
  logic active;
  logic signed [15:0] cur_lim;
  logic signed [16:0] comp_sum;
  logic off_cond;
  logic on_cond;
  logic off_reg;

  function automatic logic signed [15:0] clamp_lim(input logic signed [15:0] v,
                                                   input logic signed [15:0] dflt);
    if (v == LIMIT_DISABLED) begin
      clamp_lim = v;
    end else if (v < LIMIT_MIN || v > LIMIT_MAX) begin
      clamp_lim = dflt;
    end else begin
      clamp_lim = v;
    end
  endfunction

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      day_lim_reg <= DAY_LIMIT_RST;
      night_lim_reg <= NIGHT_LIMIT_RST;
      tc_reg <= BTC_RST;
    end else if (ce) begin
      day_lim_reg <= clamp_lim(cfg.day_heating_limit, day_lim_reg);
      night_lim_reg <= clamp_lim(cfg.night_heating_limit, night_lim_reg);
      tc_reg <= cfg.building_time_constant;
    end
  end

  always_comb begin
    if (!outside_sensor_input.sensor_short) begin
      ta_next = outside_sensor_input.sensor_temp;
    end else if (outside_sensor_input.bus_valid) begin
      ta_next = outside_sensor_input.bus_temp;
    end else begin
      ta_next = SENSOR_FAIL_TEMP;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ta_reg <= SENSOR_FAIL_TEMP;
    end else if (ce) begin
      ta_reg <= ta_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 16'h0000;
    end else if (ce) begin
      if (sample_tick) begin
        tick_cnt_reg <= 16'h0000;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
    end
  end
  assign sample_tick = (tick_cnt_reg == 16'(SAMPLE_CYCLES - 1));

  dhl_filter u_stage1 (
    .core_clk(core_clk), .rst(rst), .ce(ce), .sample_tick(sample_tick),
    .tc(tc_reg), .x(ta_reg), .y(f1)
  );
  dhl_filter u_stage2 (
    .core_clk(core_clk), .rst(rst), .ce(ce), .sample_tick(sample_tick),
    .tc(tc_reg), .x(f1), .y(f2)
  );

  assign comp_sum = {ta_reg[15], ta_reg} + {f1[15], f1};

  always_comb begin
    active = 1'b0;
    cur_lim = night_lim_reg;
    case (mode)
      DHL_AUTO: begin
        active = 1'b1;
        cur_lim = program_normal ? day_lim_reg : night_lim_reg;
      end
      DHL_CONT_REDUCED, DHL_PROTECTION: begin
        active = 1'b1;
        cur_lim = night_lim_reg;
      end
      default: begin
        active = 1'b0;
        cur_lim = night_lim_reg;
      end
    endcase
  end

  // off when any exceeds; disabled never triggers
  always_comb begin
    off_cond = ((cur_lim != LIMIT_DISABLED) &&
                ((ta_reg > cur_lim) || (composite_outside_temp > cur_lim))) ||
               ((day_lim_reg != LIMIT_DISABLED) && (f2 > day_lim_reg));
    // all one degree below, disabled counts satisfied
    on_cond = ((cur_lim == LIMIT_DISABLED) ||
               ((ta_reg <= cur_lim - HYST_TENTHS) &&
                (composite_outside_temp <= cur_lim - HYST_TENTHS))) &&
              ((day_lim_reg == LIMIT_DISABLED) || (f2 <= day_lim_reg - HYST_TENTHS));
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      off_reg <= 1'b0;
    end else if (ce) begin
      if (!active) begin
        off_reg <= 1'b0;
      end else if (!off_reg && off_cond) begin
        off_reg <= 1'b1;
      end else if (off_reg && on_cond) begin
        off_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      heating_off <= 1'b0;
      demand_shutoff <= 1'b0;
      actual_outside_temp <= SENSOR_FAIL_TEMP;
      composite_outside_temp <= SENSOR_FAIL_TEMP;
      attenuated_outside_temp <= SENSOR_FAIL_TEMP;
    end else if (ce) begin
      heating_off <= off_reg && active;
      demand_shutoff <= off_reg && active;
      actual_outside_temp <= ta_reg;
      composite_outside_temp <= comp_sum[16:1];
      attenuated_outside_temp <= f2;
    end
  end

  a_inactive_clears: assert property (@(posedge core_clk) disable iff (rst)
    (ce && !active) |=> !off_reg) else $error("off held while inactive");
  a_ind_matches: assert property (@(posedge core_clk) disable iff (rst)
    $past(ce) |-> (demand_shutoff == $past(off_reg && active)) &&
    (heating_off == demand_shutoff)) else $error("indication mismatch");
  a_off_sets: assert property (@(posedge core_clk) disable iff (rst)
    (ce && active && !off_reg && off_cond) |=> off_reg) else $error("no shutoff");
  a_hold_off: assert property (@(posedge core_clk) disable iff (rst)
    (ce && active && off_reg && !on_cond) |=> off_reg) else $error("early re-enable");
  a_fallback_zero: assert property (@(posedge core_clk) disable iff (rst)
    (ce && outside_sensor_input.sensor_short && !outside_sensor_input.bus_valid)
    |=> ta_reg == SENSOR_FAIL_TEMP) else $error("no zero fallback");
  a_night_only: assert property (@(posedge core_clk) disable iff (rst)
    (mode == DHL_CONT_REDUCED || mode == DHL_PROTECTION) |-> cur_lim == night_lim_reg)
    else $error("wrong limit");
  a_auto_day: assert property (@(posedge core_clk) disable iff (rst)
    (mode == DHL_AUTO && program_normal) |-> cur_lim == day_lim_reg)
    else $error("auto day limit");
  a_tc_zero_pass: assert property (@(posedge core_clk) disable iff (rst)
    (ce && sample_tick && tc_reg == 6'h00) |=> f1 == $past(ta_reg))
    else $error("zero tc not passthrough");
  a_att_day: assert property (@(posedge core_clk) disable iff (rst)
    (ce && active && !off_reg && day_lim_reg != LIMIT_DISABLED && f2 > day_lim_reg)
    |=> off_reg) else $error("attenuated not held to day limit");
  a_reenable: assert property (@(posedge core_clk) disable iff (rst)
    (ce && active && off_reg && on_cond) |=> !off_reg) else $error("no re-enable");
  a_disabled_quiet: assert property (@(posedge core_clk) disable iff (rst)
    (ce && active && !off_reg && cur_lim == LIMIT_DISABLED && day_lim_reg == LIMIT_DISABLED)
    |=> !off_reg) else $error("disabled limit shut off");
  a_limit_range: assert property (@(posedge core_clk) disable iff (rst)
    (day_lim_reg == LIMIT_DISABLED) || (day_lim_reg >= LIMIT_MIN && day_lim_reg <= LIMIT_MAX))
    else $error("day limit out of range");
endmodule

// *** hdl/dhl_pkg.sv ***
/*
  package for the demand heating limit logic: temperature format, defaults,
  modes, filter timing. assumes temperatures are signed tenths of a degree.
*/
package dhl_pkg;
  localparam int TEMP_W = 16;
  localparam logic signed [15:0] HYST_TENTHS = 16'sh000a;
  localparam logic signed [15:0] DAY_LIMIT_RST = 16'sh00aa;
  localparam logic signed [15:0] NIGHT_LIMIT_RST = 16'sh0032;
  localparam logic signed [15:0] LIMIT_MIN = -16'sh0032;
  localparam logic signed [15:0] LIMIT_MAX = 16'sh00fa;
  localparam logic signed [15:0] LIMIT_DISABLED = 16'sh7fff;
  localparam logic signed [15:0] SENSOR_FAIL_TEMP = 16'sh0000;
  localparam logic [5:0] BTC_RST = 6'h14;
  localparam int CLK_HZ = 40000000;
  localparam int SAMPLE_MS = 1;
  localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int ACC_FRAC = 16;

  typedef enum logic [2:0] {
    DHL_AUTO = 3'b000,
    DHL_CONT_REDUCED = 3'b001,
    DHL_CONT_NORMAL = 3'b010,
    DHL_PROTECTION = 3'b011,
    DHL_MANUAL = 3'b100
  } dhl_mode_t;

  typedef struct packed {
    logic sensor_short;
    logic bus_valid;
    logic signed [15:0] sensor_temp;
    logic signed [15:0] bus_temp;
  } dhl_source_t;

  typedef struct packed {
    logic signed [15:0] day_heating_limit;
    logic signed [15:0] night_heating_limit;
    logic [5:0] building_time_constant;
  } dhl_config_t;
endpackage

// *** hdl/dhl_filter.sv ***
/*
  one first-order recursive low-pass stage, y += (x - y) / k, k in ticks.
  assumes the caller pulses sample_tick at the fixed sample interval.
*/
`timescale 1ns/1ps
module dhl_filter
  import dhl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sample_tick,
  input wire logic [5:0] tc,
  input wire logic signed [15:0] x,
  output logic signed [15:0] y
);
  logic signed [31:0] acc_reg;
  logic signed [31:0] acc_next;
  logic signed [31:0] diff;

  // a divider per stage is costly, but ticks are rare; truncation leaves y a little short of x
  always_comb begin
    diff = ($signed({x, 16'h0000}) - acc_reg);
    if (tc == 6'h00) begin
      acc_next = $signed({x, 16'h0000});
    end else begin
      acc_next = acc_reg + (diff / $signed({26'h0000000, tc}));
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_reg <= 32'sh00000000;
    end else if (ce && sample_tick) begin
      acc_reg <= acc_next;
    end
  end

  assign y = acc_reg[31:16];
endmodule

// *** tb/dhl_outside_src.sv ***
/*
  far-side model: outside sensor, bus temperature and the configured
  building time constant. assumes the bench drives the command inputs.
*/
`timescale 1ns/1ps
module dhl_outside_src
  import dhl_pkg::*;
#(
  parameter logic [5:0] BTC = 6'h19
) (
  input wire logic signed [15:0] temp_cmd,
  input wire logic short_cmd,
  input wire logic bus_cmd,
  input wire logic signed [15:0] bus_cmd_temp,
  output dhl_source_t src,
  output logic [5:0] btc
);
  assign btc = BTC;
  // dead sensor and idle bus show junk, so a stale value cannot pass
  assign src = '{sensor_short: short_cmd, bus_valid: bus_cmd,
                 sensor_temp: (short_cmd ? ~temp_cmd : temp_cmd),
                 bus_temp: (bus_cmd ? bus_cmd_temp : ~bus_cmd_temp)};
endmodule

// *** tb/demand_heating_limit_logic_bench.sv ***
/*
  self-checking bench for dhl_core. assumes filters stay at their reset
  value until the first sample tick, so composite is half the actual temperature.
*/
`timescale 1ns/1ps
module demand_heating_limit_logic_bench;
  import dhl_pkg::*;
  logic core_clk, rst, ce, pn, short_cmd, bus_cmd, heating_off, demand_shutoff;
  logic signed [15:0] temp_cmd, bus_cmd_temp, day_lim, night_lim, act, comp, att;
  logic [5:0] btc;
  dhl_mode_t mode;
  dhl_source_t src;
  dhl_config_t cfg;
  int failures, n_tests;
  assign cfg = {day_lim, night_lim, btc};
  // light construction, so two filter ticks move both stages visibly
  dhl_outside_src #(.BTC(6'h0a)) src_model (.temp_cmd(temp_cmd), .short_cmd(short_cmd),
    .bus_cmd(bus_cmd),
    .bus_cmd_temp(bus_cmd_temp), .src(src), .btc(btc));
  dhl_core uut (.core_clk(core_clk), .rst(rst), .ce(ce), .outside_sensor_input(src),
    .cfg(cfg), .mode(mode), .program_normal(pn), .heating_off(heating_off),
    .demand_shutoff(demand_shutoff), .actual_outside_temp(act),
    .composite_outside_temp(comp), .attenuated_outside_temp(att));
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic step(input logic signed [15:0] t, input dhl_mode_t m, input logic p,
                      input logic exp_off, input logic signed [15:0] d, input logic signed [15:0] n);
    @(posedge core_clk);
    temp_cmd <= t;
    mode <= m;
    pn <= p;
    day_lim <= d;
    night_lim <= n;
    // off decision lands three edges after the input; composite adds one
    repeat (5) @(posedge core_clk);
    #1;
    check({15'h0, heating_off}, {15'h0, exp_off});
    check({15'h0, demand_shutoff}, {15'h0, exp_off});
    $display("test done at %0t", $time);
  endtask
  initial begin
    // two filter ticks plus the short steps
    repeat (2 * SAMPLE_CYCLES + 5000) @(posedge core_clk);
    failures++;
    report_and_stop;
  end
  initial begin
    {rst, ce, pn} = 3'b111;
    {short_cmd, bus_cmd} = 2'b00;
    {temp_cmd, bus_cmd_temp} = 32'h0;
    day_lim = 16'sh00aa;
    night_lim = 16'sh0032;
    mode = DHL_AUTO;
    failures = 0;
    n_tests = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    step(16'sh00a0, DHL_AUTO, 1'b1, 1'b0, 16'sh00aa, 16'sh0032);
    check(act, 16'sh00a0);
    check(comp, 16'sh0050);
    step(16'sh00ab, DHL_AUTO, 1'b1, 1'b1, 16'sh00aa, 16'sh0032);
    step(16'sh00a5, DHL_AUTO, 1'b1, 1'b1, 16'sh00aa, 16'sh0032);
    step(16'sh00a0, DHL_AUTO, 1'b1, 1'b0, 16'sh00aa, 16'sh0032);
    step(16'sh003c, DHL_AUTO, 1'b0, 1'b1, 16'sh00aa, 16'sh0032);
    step(16'sh012c, DHL_CONT_NORMAL, 1'b1, 1'b0, 16'sh00aa, 16'sh0032);
    step(16'sh012c, DHL_MANUAL, 1'b0, 1'b0, 16'sh00aa, 16'sh0032);
    step(16'sh003c, DHL_CONT_REDUCED, 1'b1, 1'b1, 16'sh00aa, 16'sh0032);
    step(16'sh002d, DHL_PROTECTION, 1'b1, 1'b1, 16'sh00aa, 16'sh0032);
    step(16'sh0028, DHL_PROTECTION, 1'b1, 1'b0, 16'sh00aa, 16'sh0032);
    step(16'sh00c8, DHL_AUTO, 1'b1, 1'b1, 16'sh0104, 16'sh0032);
    step(16'sh012c, DHL_AUTO, 1'b1, 1'b0, LIMIT_DISABLED, 16'sh0032);
    step(16'sh00fb, DHL_AUTO, 1'b1, 1'b1, LIMIT_MAX, 16'sh0032);
    step(16'sh012c, DHL_AUTO, 1'b0, 1'b0, LIMIT_MAX, LIMIT_DISABLED);
    // night limit far above, so only attenuated against day can shut off
    step(16'sh0064, DHL_PROTECTION, 1'b1, 1'b1, LIMIT_MIN, LIMIT_MAX);
    @(posedge core_clk);
    short_cmd <= 1'b1;
    step(16'sh012c, DHL_AUTO, 1'b1, 1'b0, 16'sh00aa, 16'sh0032);
    check(act, SENSOR_FAIL_TEMP);
    @(posedge core_clk);
    bus_cmd <= 1'b1;
    bus_cmd_temp <= 16'sh007b;
    step(16'sh012c, DHL_AUTO, 1'b1, 1'b0, 16'sh00aa, 16'sh0032);
    check(act, 16'sh007b);
    // ce low must freeze the sampled temperature
    @(posedge core_clk);
    ce <= 1'b0;
    bus_cmd_temp <= 16'sh00c8;
    repeat (4) @(posedge core_clk);
    #1;
    check(act, 16'sh007b);
    @(posedge core_clk);
    ce <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check(act, 16'sh00c8);
    $display("test done at %0t", $time);
    // one filter step per tick; stage two sees stage one's value from before the tick
    repeat (SAMPLE_CYCLES) @(posedge core_clk);
    #1;
    check(comp, 16'sh006e);
    check(att, 16'sh0000);
    repeat (SAMPLE_CYCLES) @(posedge core_clk);
    #1;
    check(comp, 16'sh0077);
    check(att, 16'sh0002);
    $display("test done at %0t", $time);
    report_and_stop;
  end
endmodule
